// ==== core/cfgctl_pkg.sv ====
// package: scheme codes, states, timing counts and pin bundles for the config controller
package cfgctl_pkg;
	localparam int CFGCTL_SEL_W = 4;
	// scheme codes, low three bits only on parts without the parallel-flash scheme
	localparam logic [3:0] CFGCTL_SEL_SELF_SERIAL = 4'h2;
	localparam logic [3:0] CFGCTL_SEL_SELF_PARALLEL = 4'h8;
	localparam logic [3:0] CFGCTL_SEL_PASSIVE_SERIAL = 4'h0;
	localparam logic [3:0] CFGCTL_SEL_PASSIVE_BYTE = 4'hE;
	localparam int CFGCTL_CLK_NS = 10;
	localparam int CFGCTL_POR_NS = 100000;
	localparam int CFGCTL_POR_CYC = (CFGCTL_POR_NS + CFGCTL_CLK_NS - 1) / CFGCTL_CLK_NS;
	localparam int CFGCTL_CLKDIV = 2;
	localparam int CFGCTL_DATA_W = 8;
	localparam int CFGCTL_LEN = 64;
	localparam int CFGCTL_INIT_CYC = 16;
	localparam int CFGCTL_CNT_W = 24;

	typedef enum logic [2:0] {
		CFGCTL_POR = 3'b000,
		CFGCTL_LOAD = 3'b001,
		CFGCTL_INIT = 3'b011,
		CFGCTL_USER = 3'b010,
		CFGCTL_ERR = 3'b110,
		CFGCTL_RESTART = 3'b100
	} cfgctl_state_t;

	// open-drain pin: out is always low, enable pulls it
	typedef struct packed {
		logic out;
		logic oe;
	} cfgctl_od_t;
endpackage : cfgctl_pkg

// ==== core/cfgctl_sample.sv ====
// block: scheme decode and rising-edge detect on the passive configuration clock
`timescale 1ns/1ns
module cfgctl_sample #(
	parameter int DATA_W = 8
) (
	input wire logic clk_i, // system clock
	input wire logic rst_n_i, // async reset
	input wire logic ce_i, // clock enable
	input wire logic [3:0] scheme_select_i, // static scheme straps
	input wire logic config_clock_i, // host clock, passive schemes
	input wire logic [DATA_W-1:0] data_i, // host data
	output logic self_load_o, // self-loading scheme selected
	output logic passive_byte_o, // byte-wide passive scheme
	output logic valid_scheme_o, // code is a known scheme
	output logic edge_o // rising edge of config_clock seen
);
	import cfgctl_pkg::*;
	logic clk_q;
	wire rise = config_clock_i & ~clk_q;
	wire is_ss = scheme_select_i == CFGCTL_SEL_SELF_SERIAL;
	wire is_sp = scheme_select_i == CFGCTL_SEL_SELF_PARALLEL;
	wire is_ps = scheme_select_i == CFGCTL_SEL_PASSIVE_SERIAL;
	wire is_pb = scheme_select_i == CFGCTL_SEL_PASSIVE_BYTE;
	assign self_load_o = is_ss | is_sp; // RULE1
	assign passive_byte_o = is_pb;
	assign valid_scheme_o = is_ss | is_sp | is_ps | is_pb; // RULE1
	assign edge_o = rise; // RULE18
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_q <= 1'b0;
		end else if (ce_i) begin
			clk_q <= config_clock_i;
		end
	end
	wire unused_data = ^data_i;
endmodule : cfgctl_sample

// ==== core/cfgctl_top.sv ====
// config controller: power-up, load, init, user mode and chain hand-off
// Function
// RULE1 - scheme chosen from four static select bits
// RULE2 - restart low in user mode: reset, I/O tri-state
// RULE3 - restart high again starts new configuration
// RULE4 - host reconfigures only by pulsing restart low
// RULE5 - status held low until power-on interval ends
// RULE6 - load error pulls status line low
// RULE7 - external status low while loading means error
// RULE8 - user mode ignores status line transitions
// RULE9 - done line low before and during loading
// RULE10 - done line released when initialization begins
// RULE11 - user mode entered only after done seen high
// RULE12 - done line low ignored after user mode
// RULE13 - configuration accepted only while chip enable low
// RULE14 - chain enable driven low when configuration completes
// RULE15 - board chains enable out to next chip enable
// RULE16 - self-loading schemes select external memory low
// RULE17 - self-loading schemes drive configuration clock out
// RULE18 - passive schemes capture on config clock rising
// RULE19 - status and done only low or released
// RULE20 - states: reset, load, init, user; errors back
`timescale 1ns/1ns
module cfgctl_top #(
	parameter int POR_CYC = cfgctl_pkg::CFGCTL_POR_CYC,
	parameter int LEN = cfgctl_pkg::CFGCTL_LEN,
	parameter int DATA_W = cfgctl_pkg::CFGCTL_DATA_W
) (
	input wire logic clk_i, // 100 MHz clock
	input wire logic rst_n_i, // async reset, power-up
	input wire logic ce_i, // clock enable
	input wire logic [3:0] scheme_select_i, // scheme straps
	input wire logic config_restart_n_i, // restart request, low active
	input wire logic chip_enable_n_i, // chip enable, low active
	input wire logic shared_status_n_i, // status wire level
	input wire logic config_done_line_i, // done wire level
	input wire logic config_clock_i, // host clock in passive schemes
	input wire logic [DATA_W-1:0] data_i, // configuration data
	input wire logic data_err_i, // data integrity error seen
	output cfgctl_pkg::cfgctl_od_t shared_status_n_o, // status pull-down
	output cfgctl_pkg::cfgctl_od_t config_done_line_o, // done pull-down
	output logic config_clock_o, // generated config clock
	output logic config_clock_oe_o, // config clock driven
	output logic config_mem_select_n_o, // external memory select
	output logic chain_enable_out_n_o, // enable for next device
	output logic user_io_oe_o, // user I/O may drive
	output logic [2:0] state_o // present state
);
	import cfgctl_pkg::*;
	cfgctl_state_t state, next_state;
	logic [CFGCTL_CNT_W-1:0] cnt, next_cnt;
	logic self_load, passive_byte, valid_scheme, cap_edge;
	logic [2:0] clkdiv;
	logic [DATA_W-1:0] shadow;
	logic status_pull, done_pull, gen_clk, gen_oe, mem_sel_n, ceo_n, io_oe;

	cfgctl_sample #(.DATA_W(DATA_W)) u_sample (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.scheme_select_i(scheme_select_i),
		.config_clock_i(config_clock_i),
		.data_i(data_i),
		.self_load_o(self_load),
		.passive_byte_o(passive_byte),
		.valid_scheme_o(valid_scheme),
		.edge_o(cap_edge)
	);

	function automatic logic cnt_done(input logic [CFGCTL_CNT_W-1:0] c, input int lim);
		cnt_done = c >= CFGCTL_CNT_W'(lim - 1);
	endfunction : cnt_done

	wire restart = ~config_restart_n_i;
	// self-loading: our divided clock is the word strobe
	wire gen_tick = clkdiv == 3'(CFGCTL_CLKDIV - 1);
	wire word_tick = self_load ? (gen_tick & gen_clk) : cap_edge; // RULE17 RULE18
	wire accept = ~chip_enable_n_i & valid_scheme; // RULE13
	wire ext_status_low = ~shared_status_n_i & ~status_pull;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
		CFGCTL_POR: begin
			next_cnt = cnt + 1'b1;
			if (cnt_done(cnt, POR_CYC)) begin // RULE5
				next_state = restart ? CFGCTL_RESTART : CFGCTL_LOAD;
				next_cnt = '0;
			end
		end
		CFGCTL_LOAD: begin
			if (restart) begin
				next_state = CFGCTL_RESTART; // RULE20
			end else if (data_err_i | ext_status_low) begin
				next_state = CFGCTL_ERR; // RULE6 RULE7
			end else if (accept & word_tick) begin
				next_cnt = cnt + 1'b1;
				if (cnt_done(cnt, LEN)) begin
					next_state = CFGCTL_INIT; // RULE10
					next_cnt = '0;
				end
			end
		end
		CFGCTL_INIT: begin
			if (restart) begin
				next_state = CFGCTL_RESTART;
			end else if (ext_status_low) begin
				next_state = CFGCTL_ERR; // RULE7
			end else if (config_done_line_i) begin // RULE11
				next_cnt = cnt + 1'b1;
				if (cnt_done(cnt, CFGCTL_INIT_CYC)) begin
					next_state = CFGCTL_USER;
				end
			end
		end
		CFGCTL_USER: begin
			// status and done wires not examined here
			if (restart) begin // RULE2 RULE8 RULE12 RULE4
				next_state = CFGCTL_RESTART;
			end
		end
		CFGCTL_ERR: begin
			if (restart) begin
				next_state = CFGCTL_RESTART; // RULE20
			end
		end
		CFGCTL_RESTART: begin
			next_cnt = '0;
			if (!restart) begin
				next_state = CFGCTL_LOAD; // RULE3
			end
		end
		default: begin
			next_state = CFGCTL_POR;
			next_cnt = '0;
		end
		endcase
	end

	// output decode, registered below so every pin leaves a flip-flop
	wire loading = next_state == CFGCTL_LOAD;
	assign status_pull = (state == CFGCTL_POR) | (state == CFGCTL_ERR) |
		(state == CFGCTL_RESTART); // RULE5 RULE6
	wire next_status_pull = (next_state == CFGCTL_POR) | (next_state == CFGCTL_ERR) |
		(next_state == CFGCTL_RESTART);
	wire next_done_pull = (next_state != CFGCTL_INIT) & (next_state != CFGCTL_USER); // RULE9
	wire next_mem_sel_n = ~(loading & self_load & accept); // RULE16
	wire next_ceo_n = ~(next_state == CFGCTL_USER); // RULE14
	wire next_io_oe = next_state == CFGCTL_USER; // RULE2

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= CFGCTL_POR;
			cnt <= '0;
		end else if (ce_i) begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clkdiv <= 3'h0;
			gen_clk <= 1'b0;
			gen_oe <= 1'b0;
		end else if (ce_i) begin
			gen_oe <= loading & self_load; // RULE17
			clkdiv <= (gen_tick | ~gen_oe) ? 3'h0 : clkdiv + 3'h1;
			gen_clk <= gen_oe & (gen_tick ? ~gen_clk : gen_clk);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_pull <= 1'b1;
			mem_sel_n <= 1'b1;
			ceo_n <= 1'b1;
			io_oe <= 1'b0;
			shadow <= '0;
		end else if (ce_i) begin
			done_pull <= next_done_pull;
			mem_sel_n <= next_mem_sel_n;
			ceo_n <= next_ceo_n;
			io_oe <= next_io_oe;
			if (state == CFGCTL_LOAD && accept && word_tick) begin
				shadow <= passive_byte ? data_i : {shadow[DATA_W-2:0], data_i[0]}; // RULE18
			end
		end
	end

	logic stat_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat_q <= 1'b1;
		end else if (ce_i) begin
			stat_q <= next_status_pull;
		end
	end

	// open-drain: data fixed low, only enables move
	assign shared_status_n_o = '{out: 1'b0, oe: stat_q}; // RULE19
	assign config_done_line_o = '{out: 1'b0, oe: done_pull}; // RULE19
	assign config_clock_o = gen_clk;
	assign config_clock_oe_o = gen_oe;
	assign config_mem_select_n_o = mem_sel_n;
	assign chain_enable_out_n_o = ceo_n;
	assign user_io_oe_o = io_oe;
	assign state_o = state;

	wire unused_shadow = ^shadow;

	// status pull is registered from next state, so it tracks the state in the same cycle
	por_status_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE5
		state == CFGCTL_POR |-> shared_status_n_o.oe)
		else $error("status released during power-on");
	err_pull_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE6
		ce_i && state == CFGCTL_LOAD && data_err_i && !restart |=> shared_status_n_o.oe)
		else $error("error did not pull status");
	ext_err_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
		ce_i && state == CFGCTL_INIT && ext_status_low && !restart |=> state == CFGCTL_ERR)
		else $error("external status low not taken");
	user_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
		state == CFGCTL_USER && !restart |=> state == CFGCTL_USER)
		else $error("user mode left without restart");
	done_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE9
		state == CFGCTL_LOAD && $past(state) == CFGCTL_LOAD |-> config_done_line_o.oe)
		else $error("done released while loading");
	sequence s_init_seen;
		ce_i && state == CFGCTL_INIT && !restart && !ext_status_low;
	endsequence
	done_rel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE10
		s_init_seen ##1 state == CFGCTL_INIT |-> !config_done_line_o.oe)
		else $error("done not released in init");
	user_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE11
		$rose(state == CFGCTL_USER) |-> $past(config_done_line_i))
		else $error("user mode without done high");
	restart_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
		ce_i && state == CFGCTL_USER && restart |=> !user_io_oe_o && chain_enable_out_n_o)
		else $error("restart did not tri-state");
	chain_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE14
		state == CFGCTL_USER && $past(state) == CFGCTL_USER |-> !chain_enable_out_n_o)
		else $error("chain enable not low in user");
	od_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE19
		!shared_status_n_o.out && !config_done_line_o.out)
		else $error("open-drain driven high");
	ce_freeze_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!ce_i |=> $stable(state) && $stable(cnt))
		else $error("state moved with clock enable low");
endmodule : cfgctl_top

// ==== verification/cfgctl_host.sv ====
// partner: configuration host and memory driving clock and data
`timescale 1ns/1ns
module cfgctl_host (
	input wire logic clk_i, // system clock
	input wire logic mem_select_n_i, // memory select from device
	input wire logic gen_clock_i, // clock made by device
	output logic config_clock_o, // host clock, still between frames
	output logic [7:0] data_o // data, scrambled when not driven
);
	logic sending;
	logic gen_q;
	initial begin
		sending = 1'b0;
		gen_q = 1'b0;
		config_clock_o = 1'b0;
		data_o = 8'h00;
	end
	// released bus flips every cycle so no stale value looks valid
	always @(posedge clk_i) begin
		gen_q <= gen_clock_i;
		if (!sending) begin
			if (!mem_select_n_i && gen_clock_i && !gen_q) begin
				data_o <= data_o + 8'h11;
			end else if (mem_select_n_i) begin
				data_o <= ~data_o;
			end
		end
	end
	// one word per rising edge, data set up well before it
	task automatic send(input int n);
		@(posedge clk_i);
		sending <= 1'b1;
		for (int k = 0; k < n; k++) begin
			@(posedge clk_i);
			data_o <= 8'h30 + 8'(k);
			repeat (3) @(posedge clk_i);
			config_clock_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			config_clock_o <= 1'b0;
		end
		@(posedge clk_i);
		sending <= 1'b0;
	endtask : send
endmodule : cfgctl_host

// ==== verification/config_control_handshake_tb.sv ====
// testbench: bring-up, restart, error, done hold-off and chain enable
`timescale 1ns/1ns
module config_control_handshake_tb;
	import cfgctl_pkg::*;
	localparam int POR = 20;
	localparam int NW = 4;
	typedef struct packed {
		logic [3:0] sel;
		logic self_ld;
		logic loads;
	} cfgctl_row_t;
	// invalid code first: the hand tests after the loop start from user mode
	localparam cfgctl_row_t ROWS [5] = '{
		'{4'h5, 1'b0, 1'b0},
		'{CFGCTL_SEL_SELF_SERIAL, 1'b1, 1'b1},
		'{CFGCTL_SEL_SELF_PARALLEL, 1'b1, 1'b1},
		'{CFGCTL_SEL_PASSIVE_SERIAL, 1'b0, 1'b1},
		'{CFGCTL_SEL_PASSIVE_BYTE, 1'b0, 1'b1}};
	logic clk_i = 1'b0;
	logic rst_n = 1'b0;
	logic restart_n = 1'b1;
	logic chip_en_n = 1'b0;
	logic data_err = 1'b0;
	logic ce = 1'b1;
	logic ext_status = 1'b0;
	logic ext_done = 1'b0;
	logic [3:0] sel = 4'h5;
	cfgctl_od_t st_o;
	cfgctl_od_t dn_o;
	logic gclk, gclk_oe, mem_sel_n, chain_n, io_oe, hclk;
	logic [2:0] state;
	logic [7:0] hdata;
	int bad_count = 0;
	int checks_done = 0;
	// wired-AND with pull-ups: any enabled party pulls low
	wire status_w = !(st_o.oe | ext_status);
	wire done_w = !(dn_o.oe | ext_done);
	wire config_clock = gclk_oe ? gclk : hclk;
	initial forever #5 clk_i = ~clk_i;
	cfgctl_top #(.POR_CYC(POR), .LEN(NW), .DATA_W(8)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n),
		.ce_i(ce), .scheme_select_i(sel), .config_restart_n_i(restart_n),
		.chip_enable_n_i(chip_en_n), .shared_status_n_i(status_w), .config_done_line_i(done_w),
		.config_clock_i(config_clock), .data_i(hdata), .data_err_i(data_err), .shared_status_n_o(st_o),
		.config_done_line_o(dn_o), .config_clock_o(gclk), .config_clock_oe_o(gclk_oe),
		.config_mem_select_n_o(mem_sel_n), .chain_enable_out_n_o(chain_n),
		.user_io_oe_o(io_oe), .state_o(state));
	cfgctl_host u_host (.clk_i(clk_i), .mem_select_n_i(mem_sel_n), .gen_clock_i(gclk),
		.config_clock_o(hclk), .data_o(hdata));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic wait_state(input logic [2:0] s, input int bound);
		for (int n = 0; n < bound; n++) begin
			@(negedge clk_i);
			if (state === s) return;
		end
		check("state_wait", 8'(s), 8'(state));
		report_and_stop();
	endtask : wait_state
	task automatic start_load(input logic [3:0] code);
		@(posedge clk_i);
		sel <= code;
		restart_n <= 1'b0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		check("restart", 8'(CFGCTL_RESTART), 8'(state));
		check("io_off", 8'h00, 8'(io_oe));
		@(posedge clk_i);
		restart_n <= 1'b1;
		wait_state(CFGCTL_LOAD, 10);
	endtask : start_load
	task automatic finish_load(input logic self_ld);
		if (!self_ld) u_host.send(NW);
		wait_state(CFGCTL_INIT, 200);
		repeat (2) @(negedge clk_i);
		check("done_free", 8'h00, 8'(dn_o.oe));
		wait_state(CFGCTL_USER, 40);
		@(negedge clk_i);
		check("chain_n", 8'h00, 8'(chain_n));
		check("io_on", 8'h01, 8'(io_oe));
	endtask : finish_load
	initial begin
		repeat (7) @(posedge clk_i);
		@(negedge clk_i);
		check("rst_status", 8'h01, 8'(st_o.oe));
		check("rst_done", 8'h01, 8'(dn_o.oe));
		check("rst_state", 8'(CFGCTL_POR), 8'(state));
		@(posedge clk_i);
		rst_n <= 1'b1;
		repeat (POR - 2) @(negedge clk_i);
		check("por_status", 8'h01, 8'(st_o.oe));
		wait_state(CFGCTL_LOAD, 10);
		repeat (2) @(negedge clk_i);
		check("por_free", 8'h00, 8'(st_o.oe));
		check("pull_lvl", 8'h00, 8'(st_o.out));
		foreach (ROWS[i]) begin
			start_load(ROWS[i].sel);
			@(negedge clk_i);
			check("done_pull", 8'h01, 8'(dn_o.oe));
			if (ROWS[i].loads) begin
				check("mem_sel_n", 8'(!ROWS[i].self_ld), 8'(mem_sel_n));
				check("clk_oe", 8'(ROWS[i].self_ld), 8'(gclk_oe));
				finish_load(ROWS[i].self_ld);
			end else begin
				repeat (100) @(negedge clk_i);
				check("bad_code", 8'(CFGCTL_LOAD), 8'(state));
			end
		end
		@(posedge clk_i);
		ext_status <= 1'b1;
		ext_done <= 1'b1;
		repeat (10) @(negedge clk_i);
		check("user_keep", 8'(CFGCTL_USER), 8'(state));
		check("chain_keep", 8'h00, 8'(chain_n));
		@(posedge clk_i);
		ext_status <= 1'b0;
		start_load(CFGCTL_SEL_PASSIVE_BYTE);
		u_host.send(NW);
		wait_state(CFGCTL_INIT, 200);
		repeat (40) @(negedge clk_i);
		check("init_wait", 8'(CFGCTL_INIT), 8'(state));
		@(posedge clk_i);
		ext_done <= 1'b0;
		wait_state(CFGCTL_USER, 30);
		start_load(CFGCTL_SEL_PASSIVE_SERIAL);
		@(posedge clk_i);
		ext_status <= 1'b1;
		repeat (3) @(posedge clk_i);
		ext_status <= 1'b0;
		wait_state(CFGCTL_ERR, 5);
		repeat (20) @(negedge clk_i);
		check("err_hold", 8'(CFGCTL_ERR), 8'(state));
		start_load(CFGCTL_SEL_PASSIVE_SERIAL);
		@(posedge clk_i);
		data_err <= 1'b1;
		wait_state(CFGCTL_ERR, 10);
		repeat (2) @(negedge clk_i);
		check("err_status", 8'h01, 8'(st_o.oe));
		@(posedge clk_i);
		data_err <= 1'b0;
		start_load(CFGCTL_SEL_PASSIVE_BYTE);
		@(posedge clk_i);
		chip_en_n <= 1'b1;
		u_host.send(NW);
		repeat (30) @(negedge clk_i);
		check("ce_refuse", 8'(CFGCTL_LOAD), 8'(state));
		@(posedge clk_i);
		chip_en_n <= 1'b0;
		u_host.send(NW);
		wait_state(CFGCTL_INIT, 200);
		// clock enable low must freeze the init count well past its length
		@(posedge clk_i);
		ce <= 1'b0;
		repeat (40) @(negedge clk_i);
		check("ce_freeze", 8'(CFGCTL_INIT), 8'(state));
		check("ce_done", 8'h00, 8'(dn_o.oe));
		@(posedge clk_i);
		ce <= 1'b1;
		wait_state(CFGCTL_USER, 30);
		report_and_stop();
	end
endmodule : config_control_handshake_tb
